// [ipb_prio_bank.sv]
`timescale 1ns/100ps
`default_nettype none
module ipb_prio_bank
    import ipb_pkg::*;
(
    input wire logic clk,
    input wire logic arst_n,
    input wire logic [IPB_ADDR_W-1:0] regAddr,
    input wire logic [IPB_DATA_W-1:0] regWdata,
    input wire logic regWr,
    input wire logic regRd,
    output logic [IPB_DATA_W-1:0] regRdata,
    input wire logic [IPB_NUM_SRC-1:0] srcPending,
    output ipb_level_type coreTick,
    output ipb_level_type softIrqA,
    output ipb_level_type softIrqB,
    output ipb_level_type extIrqA,
    output ipb_level_type tmrA,
    output ipb_level_type inCapA,
    output ipb_level_type outCmpA,
    output ipb_level_type extIrqB,
    output ipb_level_type tmrB,
    output ipb_level_type inCapB,
    output ipb_level_type outCmpB,
    output ipb_level_type extIrqC,
    output ipb_winner_type winner
);
    typedef struct packed {
        logic [IPB_DATA_W-1:0] rdata;
        ipb_winner_type win;
    } ipb_bank_state_type;

    ipb_bank_state_type state_q;
    ipb_bank_state_type state_d;
    ipb_level_type lvl [IPB_NUM_SRC];
    logic [IPB_DATA_W-1:0] ctrlWord [IPB_NUM_REG];
    logic [IPB_DATA_W-1:0] statusWord;

    // one slot per source; source number = register*4 + byte lane
    for (genvar i = 0; i < IPB_NUM_SRC; i++) begin : gSlot
        localparam int REG = i / IPB_LANES;
        localparam int LANE = i % IPB_LANES;
        logic slotWr;
        // upper three bits of each lane never reach the slot
        assign slotWr = regWr && (regAddr == IPB_OFF_CTRL[REG]);
        ipb_level_slot uSlot (
            .clk(clk),
            .arst_n(arst_n),
            .wrEn(slotWr),
            .wrField(regWdata[LANE*IPB_LANE_W +: IPB_FIELD_W]),
            .level(lvl[i])
        );
    end

    // readback words, unimplemented bits forced to zero
    for (genvar r = 0; r < IPB_NUM_REG; r++) begin : gWord
        for (genvar l = 0; l < IPB_LANES; l++) begin : gLane
            assign ctrlWord[r][l*IPB_LANE_W +: IPB_LANE_W] =
                {3'h0, lvl[r*IPB_LANES + l]};
        end
    end

    // status shows the arbiter's current pick
    always_comb begin
        statusWord = '0;
        statusWord[IPB_STAT_IDX_LSB +: IPB_IDX_W] = state_q.win.idx;
        statusWord[IPB_STAT_VALID_BIT] = state_q.win.valid;
        statusWord[IPB_STAT_LVL_LSB +: IPB_FIELD_W] = state_q.win.level;
    end

    // next state: read mux and arbitration
    always_comb begin
        logic found;
        ipb_level_type best;
        logic [IPB_IDX_W-1:0] bestIdx;
        found = 1'b0;
        best = IPB_LEVEL_RST;
        bestIdx = '0;
        state_d = state_q;
        // read data stand only in the cycle after the strobe
        state_d.rdata = IPB_RDATA_IDLE;
        if (regRd) begin
            case (regAddr)
                IPB_OFF_CTRL0: state_d.rdata = ctrlWord[0];
                IPB_OFF_CTRL1: state_d.rdata = ctrlWord[1];
                IPB_OFF_CTRL2: state_d.rdata = ctrlWord[2];
                IPB_OFF_STATUS: state_d.rdata = statusWord;
                default: state_d.rdata = IPB_RDATA_IDLE;
            endcase
        end
        // strict compare: on a full tie the lower source number wins
        for (int i = 0; i < IPB_NUM_SRC; i++) begin
            if (srcPending[i] && lvl[i].prio != IPB_PRIO_OFF) begin
                if (!found || lvl[i] > best) begin
                    found = 1'b1;
                    best = lvl[i];
                    bestIdx = IPB_IDX_W'(i);
                end
            end
        end
        state_d.win.valid = found;
        state_d.win.idx = bestIdx;
        state_d.win.level = best;
    end

    // registered so outputs are clean flops
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            state_q.rdata <= IPB_RDATA_IDLE;
            state_q.win <= '0;
        end else begin
            state_q <= state_d;
        end
    end

    assign regRdata = state_q.rdata;
    assign winner = state_q.win;

    // levels shown at the outputs continuously
    assign extIrqA = lvl[IPB_SRC_EXT_A];
    assign softIrqB = lvl[IPB_SRC_SOFT_B];
    assign softIrqA = lvl[IPB_SRC_SOFT_A];
    assign coreTick = lvl[IPB_SRC_CORE_TICK];
    assign extIrqB = lvl[IPB_SRC_EXT_B];
    assign outCmpA = lvl[IPB_SRC_OUT_CMP_A];
    assign inCapA = lvl[IPB_SRC_IN_CAP_A];
    assign tmrA = lvl[IPB_SRC_TMR_A];
    assign extIrqC = lvl[IPB_SRC_EXT_C];
    assign outCmpB = lvl[IPB_SRC_OUT_CMP_B];
    assign inCapB = lvl[IPB_SRC_IN_CAP_B];
    assign tmrB = lvl[IPB_SRC_TMR_B];
endmodule // ipb_prio_bank
`default_nettype wire

// [ipb_pkg.sv]
`default_nettype none
package ipb_pkg;
    // sizes of the bank
    localparam int IPB_NUM_SRC = 12;
    localparam int IPB_NUM_REG = 3;
    localparam int IPB_LANES = 4;
    localparam int IPB_LANE_W = 8;
    localparam int IPB_FIELD_W = 5;
    localparam int IPB_ADDR_W = 8;
    localparam int IPB_DATA_W = 32;
    localparam int IPB_IDX_W = 4;

    // register byte offsets
    localparam logic [7:0] IPB_OFF_CTRL0 = 8'h00;
    localparam logic [7:0] IPB_OFF_CTRL1 = 8'h04;
    localparam logic [7:0] IPB_OFF_CTRL2 = 8'h08;
    localparam logic [7:0] IPB_OFF_STATUS = 8'h0c;
    localparam logic [7:0] IPB_OFF_CTRL [IPB_NUM_REG] =
        '{IPB_OFF_CTRL0, IPB_OFF_CTRL1, IPB_OFF_CTRL2};

    // field layout inside one byte lane
    localparam int IPB_SUB_LSB = 0;
    localparam int IPB_PRIO_LSB = 2;

    // status register layout
    localparam int IPB_STAT_IDX_LSB = 0;
    localparam int IPB_STAT_VALID_BIT = 7;
    localparam int IPB_STAT_LVL_LSB = 8;

    // reset values
    localparam logic [2:0] IPB_PRIO_OFF = 3'h0;
    localparam logic [1:0] IPB_SUB_RST = 2'h0;
    localparam logic [31:0] IPB_RDATA_IDLE = 32'h0000_0000;

    // source numbering: register index times four plus byte lane
    localparam int IPB_SRC_CORE_TICK = 0;
    localparam int IPB_SRC_SOFT_A = 1;
    localparam int IPB_SRC_SOFT_B = 2;
    localparam int IPB_SRC_EXT_A = 3;
    localparam int IPB_SRC_TMR_A = 4;
    localparam int IPB_SRC_IN_CAP_A = 5;
    localparam int IPB_SRC_OUT_CMP_A = 6;
    localparam int IPB_SRC_EXT_B = 7;
    localparam int IPB_SRC_TMR_B = 8;
    localparam int IPB_SRC_IN_CAP_B = 9;
    localparam int IPB_SRC_OUT_CMP_B = 10;
    localparam int IPB_SRC_EXT_C = 11;

    typedef struct packed {
        logic [2:0] prio;
        logic [1:0] subprio;
    } ipb_level_type;

    typedef struct packed {
        logic valid;
        logic [IPB_IDX_W-1:0] idx;
        ipb_level_type level;
    } ipb_winner_type;

    localparam ipb_level_type IPB_LEVEL_RST = '{IPB_PRIO_OFF, IPB_SUB_RST};
endpackage
`default_nettype wire

// [ipb_level_slot.sv]
`timescale 1ns/100ps
`default_nettype none
module ipb_level_slot
    import ipb_pkg::*;
(
    input wire logic clk,
    input wire logic arst_n,
    input wire logic wrEn,
    input wire logic [IPB_FIELD_W-1:0] wrField,
    output ipb_level_type level
);
    typedef struct packed {
        ipb_level_type level;
    } ipb_slot_state_type;

    ipb_slot_state_type state_q;
    ipb_slot_state_type state_d;

    // software write replaces the whole field
    always_comb begin
        state_d = state_q;
        if (wrEn) begin
            state_d.level.prio = wrField[IPB_PRIO_LSB +: 3];
            state_d.level.subprio = wrField[IPB_SUB_LSB +: 2];
        end
    end

    // power-on value leaves the source disabled
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            state_q.level <= IPB_LEVEL_RST;
        end else begin
            state_q <= state_d;
        end
    end

    assign level = state_q.level;
endmodule // ipb_level_slot
`default_nettype wire

// [ipb_prio_bank_properties.sv]
`timescale 1ns/100ps
`default_nettype none
module ipb_prio_bank_chk
    import ipb_pkg::*;
(
    input wire logic clk,
    input wire logic arst_n,
    input wire logic [IPB_ADDR_W-1:0] regAddr,
    input wire logic [IPB_DATA_W-1:0] regWdata,
    input wire logic regWr,
    input wire logic regRd,
    input wire logic [IPB_DATA_W-1:0] regRdata,
    input wire logic [IPB_NUM_SRC-1:0] srcPending,
    input wire ipb_level_type coreTick,
    input wire ipb_level_type extIrqA,
    input wire ipb_level_type outCmpA,
    input wire ipb_level_type inCapB,
    input wire ipb_level_type tmrB,
    input wire ipb_winner_type winner
);
    default clocking @(posedge clk); endclocking
    default disable iff (!arst_n);
    // read data only right after a strobe, holes zero on every read but status
    property p_gap; regRdata != 0 |-> $past(regRd); endproperty
    a_gap: assert property (p_gap) else $error("stray read data");
    // status keeps its valid flag in bit 7, so every read but status is held, unmapped ones too
    property p_hole; regRd && regAddr != IPB_OFF_STATUS
        |=> (regRdata & 32'he0e0e0e0) == 0; endproperty
    a_hole: assert property (p_hole) else $error("hole bits set");
    // a write lands in its lane one cycle later
    property p_extA; regWr && regAddr == IPB_OFF_CTRL0
        |=> extIrqA == $past(regWdata[28:24]); endproperty
    a_extA: assert property (p_extA) else $error("lane 3 write");
    property p_tick; regWr && regAddr == IPB_OFF_CTRL0
        |=> coreTick == $past(regWdata[4:0]); endproperty
    a_tick: assert property (p_tick) else $error("lane 0 write");
    property p_ocA; regWr && regAddr == IPB_OFF_CTRL1
        |=> outCmpA == $past(regWdata[20:16]); endproperty
    a_ocA: assert property (p_ocA) else $error("lane 2 write");
    property p_icB; regWr && regAddr == IPB_OFF_CTRL2
        |=> inCapB == $past(regWdata[12:8]); endproperty
    a_icB: assert property (p_icB) else $error("lane 1 write");
    property p_rdT; regRd && regAddr == IPB_OFF_CTRL2
        |=> regRdata[4:0] == tmrB; endproperty
    a_rdT: assert property (p_rdT) else $error("readback lane 0");
    // nothing pending or top level pending
    property p_none; srcPending == 0 |=> !winner.valid; endproperty
    a_none: assert property (p_none) else $error("winner w/o req");
    property p_top; srcPending[IPB_SRC_EXT_A] && extIrqA == 5'h1f
        |=> winner.valid && winner.level == 5'h1f; endproperty
    a_top: assert property (p_top) else $error("top not chosen");
endmodule // ipb_prio_bank_chk
bind ipb_prio_bank ipb_prio_bank_chk chk_u (.clk, .arst_n, .regAddr,
    .regWdata, .regWr, .regRd, .regRdata, .srcPending, .coreTick,
    .extIrqA, .outCmpA, .inCapB, .tmrB, .winner);
`default_nettype wire

// [ipb_prio_bank_tb.sv]
`timescale 1ns/100ps
`default_nettype none
module ipb_prio_bank_tb
    import ipb_pkg::*;
;
    logic clk = 0;
    logic arst_n = 0;
    logic [7:0] regAddr = '0;
    logic [31:0] regWdata = '0;
    logic [31:0] regRdata;
    logic regWr = 0;
    logic regRd = 0;
    logic [11:0] srcPending = '0;
    ipb_level_type coreTick, softIrqA, softIrqB, extIrqA, tmrA, inCapA;
    ipb_level_type outCmpA, extIrqB, tmrB, inCapB, outCmpB, extIrqC;
    ipb_winner_type winner;
    int mismatches = 0;
    int compares = 0;
    always #20 clk = ~clk;
    ipb_prio_bank dut_u (.clk, .arst_n, .regAddr, .regWdata, .regWr,
        .regRd, .regRdata, .srcPending, .coreTick, .softIrqA, .softIrqB,
        .extIrqA, .tmrA, .inCapA, .outCmpA, .extIrqB, .tmrB, .inCapB,
        .outCmpB, .extIrqC, .winner);
    task automatic ck(logic [31:0] g, logic [31:0] e);
        compares++;
        if (g !== e) begin
            mismatches++;
            $display("[FAIL] %0t got %h exp %h", $time, g, e);
        end
    endtask
    task automatic cl(ipb_level_type g, logic [4:0] e);
        ck({27'h0, g}, {27'h0, e});
    endtask
    // one-cycle strobes, levels settle just after the edge
    task automatic wr(logic [7:0] a, logic [31:0] d);
        @(posedge clk);
        regWr <= 1;
        regAddr <= a;
        regWdata <= d;
        @(posedge clk);
        regWr <= 0;
        #1;
    endtask
    task automatic rd(logic [7:0] a, logic [31:0] e);
        @(posedge clk);
        regRd <= 1;
        regAddr <= a;
        @(posedge clk);
        regRd <= 0;
        #1 ck(regRdata, e);
    endtask
    // winner is registered, so allow the pending edge plus one
    task automatic arb(logic [11:0] p, logic [9:0] e);
        @(posedge clk);
        srcPending <= p;
        repeat (2) @(posedge clk);
        #1 ck({22'h0, winner}, {22'h0, e});
    endtask
    task automatic end_sim;
        $display("compares %0d mismatches %0d", compares, mismatches);
        if (mismatches == 0 && compares > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask
    initial begin
        repeat (5) @(posedge clk);
        arst_n <= 1;
        rd(IPB_OFF_CTRL0, 32'h0);
        rd(IPB_OFF_CTRL1, 32'h0);
        rd(IPB_OFF_CTRL2, 32'h0);
        $display("reset done");
        // hole bits set in every byte to prove they are dropped
        wr(IPB_OFF_CTRL0, 32'hfff1eae5);
        wr(IPB_OFF_CTRL1, 32'hfef0ebe4);
        wr(IPB_OFF_CTRL2, 32'hfdf3e8e7);
        rd(IPB_OFF_CTRL0, 32'h1f110a05);
        rd(IPB_OFF_CTRL1, 32'h1e100b04);
        rd(IPB_OFF_CTRL2, 32'h1d130807);
        @(posedge clk);
        #1 ck(regRdata, 32'h0);
        cl(extIrqA, 5'h1f);
        cl(softIrqB, 5'h11);
        cl(softIrqA, 5'h0a);
        cl(coreTick, 5'h05);
        cl(extIrqB, 5'h1e);
        cl(outCmpA, 5'h10);
        cl(inCapA, 5'h0b);
        cl(tmrA, 5'h04);
        cl(extIrqC, 5'h1d);
        cl(outCmpB, 5'h13);
        cl(inCapB, 5'h08);
        cl(tmrB, 5'h07);
        wr(8'h10, '1);
        rd(8'h10, 32'h0);
        wr(IPB_OFF_STATUS, '1);
        $display("map done");
        arb(12'h888, {1'b1, 4'h3, 5'h1f});
        rd(IPB_OFF_STATUS, 32'h00001f83);
        arb(12'h440, {1'b1, 4'ha, 5'h13});
        arb(12'h014, {1'b1, 4'h2, 5'h11});
        wr(IPB_OFF_CTRL0, 32'h0);
        // pending changes right on the edge, like every other input
        @(posedge clk);
        srcPending <= 12'h001;
        repeat (2) @(posedge clk);
        #1 ck({31'h0, winner.valid}, 32'h0);
        $display("arbiter done");
        for (int p = 0; p < 8; p++) begin
            wr(IPB_OFF_CTRL2, 32'(p) << 2);
            cl(tmrB, 5'(p << 2));
        end
        $display("codes done");
        end_sim;
    end
    initial begin
        repeat (3000) @(posedge clk);
        mismatches++;
        end_sim;
    end
endmodule // ipb_prio_bank_tb
`default_nettype wire
